/* File: logic/smfc_socket_mode.sv */
`timescale 1ns/10ps
`default_nettype none

module smfc_socket_mode #(
  parameter int UNIT_CYC = smfc_pkg::UNIT_CYCLES
) (
  input  wire logic                  mclk,                // clock
  input  wire logic                  nrst,                // sync reset, low
  input  wire logic                  host_wr,             // write strobe
  input  wire logic                  host_rd,             // read strobe
  input  wire logic [2:0]            socket_number_field, // socket select
  input  wire logic [15:0]           host_addr,           // register offset
  input  wire logic [7:0]            host_wdata,          // write data
  output logic      [7:0]            host_rdata,          // read data
  output logic                       host_rvalid,         // read data valid
  input  wire logic                  rx_valid,            // frame offered
  input  wire smfc_pkg::smfc_rx_t    rx_info,             // frame attributes
  output logic                       rx_accept,           // frame kept
  input  wire logic                  seg_valid,           // tcp data arrived
  input  wire logic [2:0]            seg_sock,            // its socket
  input  wire logic [15:0]           retry_time,          // in 0.1 ms units
  output logic      [7:0]            ack_send,            // ack now, per socket
  output logic      [7:0]            igmp_v1,             // igmp v1 selected
  output smfc_pkg::smfc_mode_t [7:0] socket_mode          // all mode regs
);
  typedef struct packed {
    smfc_pkg::smfc_mode_t [7:0] mode;
    logic [7:0][15:0]           cnt;
    logic [15:0]                pre;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [7:0]                 ack;
  } smfc_state_t;

  smfc_state_t st_reg;
  smfc_state_t st_next;
  logic        hit;
  logic        tick;
  smfc_pkg::smfc_mode_t sm;

  // filter verdict for one frame against one socket's mode byte
  function automatic logic rx_ok(smfc_pkg::smfc_mode_t m,
                                 smfc_pkg::smfc_rx_t r);
    logic ok;
    ok = 1'b0;
    if (m.proto == smfc_pkg::PROTO_UDP) begin
      ok = 1'b1;
      if (r.bcast && m.opt6) ok = 1'b0;
      if (r.mcast && !m.opt7) ok = 1'b0;
      if (m.opt7 && m.opt4 && !r.mcast && !r.bcast) ok = 1'b0;
    end else if (m.proto == smfc_pkg::PROTO_RAW) begin
      ok = 1'b1;
      if (m.opt7 && !(r.bcast || r.own_addr)) ok = 1'b0;
      if (r.bcast && m.opt6) ok = 1'b0;
      if (r.mcast && m.opt5) ok = 1'b0;
      if (r.ipv6 && m.opt4) ok = 1'b0;
    end else if (m.proto == smfc_pkg::PROTO_TCP) begin
      ok = r.own_addr && !r.bcast && !r.mcast;
    end
    return ok;
  endfunction

  assign hit  = host_addr == smfc_pkg::SOCK_MODE_OFS;
  // one unit tick every UNIT_CYC cycles, shared by all sockets
  assign tick = st_reg.pre == 16'h0000;
  assign sm   = st_reg.mode[seg_sock];

  // free-running prescaler: a delayed ack lands within one unit of the
  // requested time, never earlier than one unit short of it
  always_comb begin
    st_next        = st_reg;
    st_next.ack    = 8'h00;
    st_next.rvalid = host_rd;
    st_next.rdata  = 8'h00;
    st_next.pre    = tick ? 16'(UNIT_CYC - 1) : st_reg.pre - 16'h0001;
    if (host_rd && hit) st_next.rdata = st_reg.mode[socket_number_field];
    if (host_wr && hit) begin
      st_next.mode[socket_number_field] = host_wdata;
    end
    for (int i = 0; i < smfc_pkg::NSOCK; i++) begin
      if (tick && st_reg.cnt[i] != 16'h0000) begin
        st_next.cnt[i] = st_reg.cnt[i] - 16'h0001;
        if (st_reg.cnt[i] == 16'h0001) st_next.ack[i] = 1'b1;
      end
    end
    // an immediate ack cancels a pending one; a delayed segment that
    // arrives while one is pending merges into it
    if (seg_valid && sm.proto == smfc_pkg::PROTO_TCP) begin
      if (sm.opt5 || retry_time == 16'h0000) begin
        st_next.ack[seg_sock] = 1'b1;
        st_next.cnt[seg_sock] = 16'h0000;
      end else if (st_reg.cnt[seg_sock] == 16'h0000) begin
        st_next.cnt[seg_sock] = retry_time;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.mode <= {smfc_pkg::NSOCK{smfc_pkg::SOCK_MODE_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata  = st_reg.rdata;
  assign host_rvalid = st_reg.rvalid;
  assign ack_send    = st_reg.ack;
  assign socket_mode = st_reg.mode;
  // raw frame mode is not refused on sockets 1 to 7; the host keeps it on 0
  assign rx_accept   = rx_valid && rx_ok(st_reg.mode[rx_info.sock], rx_info);

  // version flag only means something on a udp multicast socket
  always_comb begin
    for (int i = 0; i < smfc_pkg::NSOCK; i++) begin
      igmp_v1[i] = st_reg.mode[i].proto == smfc_pkg::PROTO_UDP &&
                   st_reg.mode[i].opt7 && st_reg.mode[i].opt5;
    end
  end

  // checks
  wire smfc_pkg::smfc_mode_t rm      = st_reg.mode[rx_info.sock];
  wire logic [2:0]           nb_sock = socket_number_field + 3'd1;

  // register access and tcp ack timing
  mode_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_wr && hit ##1 host_rd && hit && !host_wr &&
    socket_number_field == $past(socket_number_field) |=>
    host_rdata == $past(host_wdata, 2))
    else $error("mode write not read back");
  rd_valid_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_rd |=> host_rvalid) else $error("read valid missing");
  rd_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
    !host_rd |=> !host_rvalid) else $error("read valid stuck");
  unmapped_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_rd && !hit |=> host_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  unmapped_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_wr && !hit |=> socket_mode == $past(socket_mode))
    else $error("unmapped write changed a mode");
  sock_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_wr |=> socket_mode[$past(nb_sock)] == $past(socket_mode[nb_sock]))
    else $error("write reached another socket");
  reset_val_a: assert property (@(posedge mclk)
    !nrst |=> socket_mode == '0) else $error("mode reset wrong");
  ack_now_a: assert property (@(posedge mclk) disable iff (!nrst)
    seg_valid && sm.proto == smfc_pkg::PROTO_TCP && sm.opt5 |=>
    ack_send[$past(seg_sock)]) else $error("immediate ack missing");
  ack_wait_a: assert property (@(posedge mclk) disable iff (!nrst)
    seg_valid && sm.proto == smfc_pkg::PROTO_TCP && !sm.opt5 &&
    retry_time != 16'h0000 && st_reg.cnt[seg_sock] == 16'h0000 |=>
    st_reg.cnt[$past(seg_sock)] == $past(retry_time))
    else $error("delayed ack not armed");
  ack_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
    seg_valid && sm.proto == smfc_pkg::PROTO_TCP && !sm.opt5 &&
    retry_time != 16'h0000 && st_reg.cnt[seg_sock] == 16'h0000 |=>
    !ack_send[$past(seg_sock)]) else $error("delayed ack sent at once");
  ack_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(seg_valid && sm.proto == smfc_pkg::PROTO_TCP) &&
    st_reg.cnt == '0 |=> ack_send == 8'h00)
    else $error("ack without a segment");

  // receive filter and igmp version flag
  raw_filter_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_RAW && rm.opt7 && !rx_info.bcast &&
    !rx_info.own_addr |-> !rx_accept) else $error("raw filter leak");
  raw_open_a: assert property (@(posedge mclk) disable iff (!nrst)
    rx_valid && rm == 8'(smfc_pkg::PROTO_RAW) |-> rx_accept)
    else $error("raw frame dropped");
  bcast_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.opt6 && rx_info.bcast |-> !rx_accept) else $error("bcast leak");
  ipv6_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_RAW && rm.opt4 && rx_info.ipv6 |->
    !rx_accept) else $error("ipv6 leak");
  mcast_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_RAW && rm.opt5 && rx_info.mcast |->
    !rx_accept) else $error("raw mcast leak");
  ucast_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_UDP && rm.opt7 && rm.opt4 &&
    !rx_info.mcast && !rx_info.bcast |-> !rx_accept)
    else $error("unicast leak");
  closed_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_CLOSED |-> !rx_accept)
    else $error("closed socket took a frame");
  udp_mcast_a: assert property (@(posedge mclk) disable iff (!nrst)
    rm.proto == smfc_pkg::PROTO_UDP && !rm.opt7 && rx_info.mcast |->
    !rx_accept) else $error("multicast taken while disabled");
  raw_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    rx_valid && rm == {1'b1, 3'b000, smfc_pkg::PROTO_RAW} &&
    (rx_info.bcast || rx_info.own_addr) |-> rx_accept)
    else $error("raw filter dropped a kept frame");
  igmp_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
    host_wr && hit && host_wdata == 8'ha2 |=>
    igmp_v1[$past(socket_number_field)]) else $error("igmp v1 not set");
  igmp_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    st_reg.mode[socket_number_field].proto != smfc_pkg::PROTO_UDP |->
    !igmp_v1[socket_number_field]) else $error("igmp v1 outside udp");

  raw_cov: cover property (@(posedge mclk) disable iff (!nrst)
    rx_accept && rm.proto == smfc_pkg::PROTO_RAW);
  delay_cov: cover property (@(posedge mclk) disable iff (!nrst)
    ack_send != 8'h00 && !$past(seg_valid));
  udp_cov: cover property (@(posedge mclk) disable iff (!nrst)
    rx_accept && rm.proto == smfc_pkg::PROTO_UDP && rx_info.mcast);
  back_cov: cover property (@(posedge mclk) disable iff (!nrst)
    host_wr && hit ##1 host_rd && hit);
  now_cov: cover property (@(posedge mclk) disable iff (!nrst)
    seg_valid && sm.proto == smfc_pkg::PROTO_TCP && sm.opt5);
endmodule // smfc_socket_mode

`default_nettype wire

/* File: include/smfc_pkg.sv */
package smfc_pkg;
  localparam int          NSOCK         = 8;
  localparam logic [15:0] SOCK_MODE_OFS = 16'h0000;
  localparam logic [7:0]  SOCK_MODE_RST = 8'h00;
  localparam logic [3:0]  PROTO_CLOSED  = 4'h0;
  localparam logic [3:0]  PROTO_TCP     = 4'h1;
  localparam logic [3:0]  PROTO_UDP     = 4'h2;
  localparam logic [3:0]  PROTO_RAW     = 4'h4;
  // retry-time unit and clock period, both in ns
  localparam int          RETRY_UNIT_NS = 100000;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          UNIT_CYCLES   = RETRY_UNIT_NS / CLK_PERIOD_NS;

  // bit 7: multicast enable / raw_addr_filter_enable
  // bit 6: broadcast_block
  // bit 5: immediate_ack / igmp_version_select / raw_multicast_block
  // bit 4: unicast_block / raw_ipv6_block
  typedef struct packed {
    logic       opt7;
    logic       opt6;
    logic       opt5;
    logic       opt4;
    logic [3:0] proto;
  } smfc_mode_t;

  typedef struct packed {
    logic [2:0] sock;
    logic       bcast;
    logic       mcast;
    logic       own_addr;
    logic       ipv6;
  } smfc_rx_t;
endpackage

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                       mclk, nrst, host_wr, host_rd, host_rvalid;
  logic                       rx_valid, seg_valid, rx_accept;
  logic [2:0]                 sn, seg_sock, mode_sock;
  logic [15:0]                host_addr, retry_time;
  logic [7:0]                 host_wdata, host_rdata, ack_send, igmp_v1, e;
  logic [7:0]                 mode_val;
  smfc_pkg::smfc_rx_t         rx_info;
  smfc_pkg::smfc_mode_t [7:0] socket_mode;
  logic [7:0]                 mdl [8];
  logic [3:0]                 pc [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  logic [31:0]                seed = 32'h3244352f, r;
  int                         fail_count = 0, cmp_count = 0, cyc = 0, n;

  smfc_socket_mode #(.UNIT_CYC(4)) dut (.mclk(mclk), .nrst(nrst),
    .host_wr(host_wr), .host_rd(host_rd), .socket_number_field(sn),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .rx_valid(rx_valid), .rx_info(rx_info),
    .rx_accept(rx_accept), .seg_valid(seg_valid), .seg_sock(seg_sock),
    .retry_time(retry_time), .ack_send(ack_send), .igmp_v1(igmp_v1),
    .socket_mode(socket_mode));

  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // k: 0 own unicast, 1 foreign unicast, 2 broadcast, 3 multicast
  function automatic logic exp_acc(input logic [7:0] m, input int k,
                                   input logic v6);
    logic b, mc, own;
    b = (k == 2);
    mc = (k == 3);
    own = (k == 0);
    case (m[3:0])
      4'h1: return own;
      4'h2: return !(b & m[6]) && !(mc & !m[7]) && !(m[7] & m[4] & !mc & !b);
      4'h4: return !(m[7] & !(b | own)) && !(m[6] & b) && !(m[5] & mc) &&
                   !(m[4] & v6);
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] s, input logic [15:0] a,
                    input logic [7:0] d);
    @(negedge mclk);
    host_wr = 1; sn = s; host_addr = a; host_wdata = d;
    @(negedge mclk);
    host_wr = 0;
    if (a == 16'h0000) mdl[s] = d;
    for (int i = 0; i < 8; i++) chk(socket_mode[i], mdl[i]);
  endtask

  task automatic rd(input logic [2:0] s, input logic [15:0] a);
    @(negedge mclk);
    host_rd = 1; sn = s; host_addr = a;
    @(negedge mclk);
    host_rd = 0;
    chk(host_rvalid, 1);
    chk(host_rdata, a == 16'h0000 ? mdl[s] : 8'h00);
  endtask

  task automatic seg(input logic [2:0] s, input logic [15:0] rt,
                     input int lo, input int hi);
    @(negedge mclk);
    seg_valid = 1; seg_sock = s; retry_time = rt;
    @(negedge mclk);
    seg_valid = 0;
    n = 1;
    while (ack_send[s] !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    {host_wr, host_rd, rx_valid, seg_valid, nrst} = '0;
    sn = 0; host_addr = 0; host_wdata = 0; seg_sock = 0; retry_time = 0;
    rx_info = '0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (3) @(negedge mclk);
    nrst = 1;
    for (int i = 0; i < 8; i++) rd(3'(i), 16'h0000);
    repeat (60) begin
      r = rnd();
      mode_val = {r[7:4], r[12:10] == 3'h0 ? r[3:0] : pc[r[9:8]]};
      mode_sock = mode_val[3:0] == 4'h4 ? 3'h0 : r[18:16];
      wr(mode_sock, 16'h0000, mode_val);
      for (int i = 0; i < 8; i++)
        e[i] = mdl[i][3:0] == 4'h2 && mdl[i][7] && mdl[i][5];
      chk(igmp_v1, e);
      rd(mode_sock, 16'h0000);
      for (int k = 0; k < 4; k++) begin
        @(negedge mclk);
        rx_valid = 1;
        rx_info = {mode_sock, k == 2, k == 3, k == 0, r[k + 20]};
        #1;
        chk(rx_accept, exp_acc(mdl[mode_sock], k, r[k + 20]));
      end
      rx_valid = 0;
    end
    wr(3'd0, 16'h0000, 8'h84);
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      rx_valid = 1;
      rx_info = {3'd0, k == 2, k == 3, k == 0, 1'b0};
      #1;
      chk(rx_accept, k == 0 || k == 2);
    end
    rx_valid = 0;
    @(negedge mclk);
    host_wr = 1;
    sn = 3'd2;
    host_addr = 16'h0000;
    host_wdata = 8'ha2;
    @(negedge mclk);
    host_wr = 0;
    host_rd = 1;
    mdl[2] = 8'ha2;
    chk(igmp_v1[2], 1);
    @(negedge mclk);
    host_rd = 0;
    chk(host_rdata, mdl[2]);
    wr(3'd3, 16'h0004, 8'h55);
    rd(3'd3, 16'h0004);
    wr(3'd5, 16'h0000, 8'h21);
    seg(3'd5, 16'h0003, 1, 1);
    wr(3'd5, 16'h0000, 8'h01);
    seg(3'd5, 16'h0000, 1, 1);
    seg(3'd5, 16'h0003, 9, 13);
    @(negedge mclk);
    nrst = 0;
    repeat (3) @(negedge mclk);
    nrst = 1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    for (int i = 0; i < 8; i++) rd(3'(i), 16'h0000);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
